/* File: rtl/rsc_reset_source_controller.sv */
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module rsc_reset_source_controller #(
  parameter int PWRT_CYCLES      = rsc_pkg::PWRT_CYC,
  parameter int MASTER_CLEAR_PIN_FILT_CYCLES = rsc_pkg::MASTER_CLEAR_PIN_FILT_CYC
) (
  input  wire logic                MCLK,
  input  wire logic                RESETN,
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  input  wire rsc_pkg::rsc_trip_s  TRIP,
  input  wire rsc_pkg::rsc_cfg_s   CFG,
  input  wire logic                MASTER_CLEAR_PIN_N,
  input  wire logic                VDD_PRESENT,
  input  wire logic                DEEP_SLEEP,
  input  wire logic                RESET_INSTR,
  input  wire logic                STACK_ERR,
  output logic                     SYSTEM_RESET,
  output logic                     BATTERY_MODE,
  output logic                     CLOCK_REINIT,
  output logic                     CONFIG_RELOAD
);
  import rsc_pkg::*;

  localparam int CMAX = (PWRT_CYCLES > INSTR_CYC) ? PWRT_CYCLES : INSTR_CYC;
  localparam int CW   = $clog2(CMAX + 2);
  localparam int FW   = $clog2(MASTER_CLEAR_PIN_FILT_CYCLES + 1);

  // word address match, shared by write decode and read mux
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    return (addr[31:8] == 24'h00_0000) && (addr[7:2] == ofs[7:2]);
  endfunction

  rsc_state_e        state_q;
  rsc_state_e        state_d;
  logic [CW-1:0]     cnt_q;
  logic [CW-1:0]     cnt_d;
  logic [FW-1:0]     master_clear_pin_cnt_q;
  logic              master_clear_pin_rst_q;
  logic [7:0]        reset_control_reg_q;
  logic [7:0]        reset_control_reg_three_q;
  logic [7:0]        dscon_q;
  logic              batt_mode_q;
  logic              sys_rst_q;
  logic              clk_reinit_q;
  logic              cfg_reload_q;
  logic              wr_pend_q;
  logic [31:0]       wr_addr_q;
  logic [31:0]       rdata_q;
  logic              addr_ok;
  logic              supply_trip;
  logic              batt_trip;
  logic              ds_trip;
  logic              volt_src;
  logic              instr_go;
  logic [31:0]       read_mux;

  // source qualification by configuration
  // supply detector sleeps in deep sleep: the dedicated, core and battery detectors still run there
  assign supply_trip = CFG.supply_brownout_enable & ~DEEP_SLEEP                // [RQ5] [RQ7]
                     & (CFG.supply_brownout_level_select ? TRIP.supply_low_2v0 // [RQ6]
                                                         : TRIP.supply_low_1v8);
  assign batt_trip   = CFG.battery_brownout_enable & TRIP.battery_low;          // [RQ11]
  assign ds_trip     = CFG.deep_sleep_brownout_enable & DEEP_SLEEP             // [RQ13]
                     & TRIP.deep_sleep_low;
  // core detector has no enable at all
  assign volt_src    = TRIP.core_low | supply_trip | batt_trip;                 // [RQ1] [RQ12]
  assign instr_go    = RESET_INSTR | (STACK_ERR & CFG.stack_error_reset_enable); // [RQ20]

  // master-clear filter: pin must stay low for the full count
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      master_clear_pin_cnt_q <= '0;
      master_clear_pin_rst_q <= 1'b0;
    end else if (MASTER_CLEAR_PIN_N) begin
      master_clear_pin_cnt_q <= '0;
      master_clear_pin_rst_q <= 1'b0;
    end else if (master_clear_pin_cnt_q == FW'(MASTER_CLEAR_PIN_FILT_CYCLES - 1)) begin
      master_clear_pin_rst_q <= 1'b1;                                                       // [RQ18] [RQ21]
    end else begin
      master_clear_pin_cnt_q <= master_clear_pin_cnt_q + FW'(1);
    end
  end

  // reset sequencer; voltage sources dominate every other state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_RUN: begin
        if (volt_src) begin
          state_d = ST_VHOLD;                                                   // [RQ22]
        end else if (master_clear_pin_rst_q) begin
          state_d = ST_MHOLD;
        end else if (instr_go) begin
          state_d = ST_IRST;                                                    // [RQ16]
          cnt_d   = '0;
        end
      end
      ST_VHOLD: begin
        if (!volt_src) begin
          state_d = ST_PWRT;
          cnt_d   = '0;
        end
      end
      ST_PWRT: begin
        if (volt_src) begin
          state_d = ST_VHOLD;
        end else if (cnt_q == CW'(PWRT_CYCLES - 1)) begin
          state_d = ST_RUN;                                                     // [RQ2] [RQ8]
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      ST_MHOLD: begin
        if (volt_src) begin
          state_d = ST_VHOLD;
        end else if (!master_clear_pin_rst_q) begin
          state_d = ST_RUN;
        end
      end
      ST_IRST: begin
        if (volt_src) begin
          state_d = ST_VHOLD;
        end else if (cnt_q == CW'(INSTR_CYC - 1)) begin
          state_d = ST_RUN;                                                     // [RQ17]
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: begin
        state_d = ST_PWRT;
        cnt_d   = '0;
      end
    endcase
  end

  // power-on starts in the timer, as a fresh supply would
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_PWRT;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // registered reset outputs, all sources merged
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sys_rst_q    <= 1'b1;
      clk_reinit_q <= 1'b1;
      cfg_reload_q <= 1'b0;
    end else begin
      sys_rst_q    <= (state_d != ST_RUN);                                      // [RQ22]
      // instruction reset keeps the running clock source
      clk_reinit_q <= (state_d == ST_VHOLD) | (state_d == ST_PWRT)            // [RQ16]
                    | (state_d == ST_MHOLD);
      cfg_reload_q <= (state_q == ST_IRST) & (state_d == ST_RUN);              // [RQ17]
    end
  end

  // battery mode entered on battery trip without main supply, left only when supply returns
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      batt_mode_q <= 1'b0;
    end else if (VDD_PRESENT) begin
      batt_mode_q <= 1'b0;
    end else if (batt_trip) begin
      batt_mode_q <= 1'b1;                                                      // [RQ12]
    end
  end

  // ahb-lite slave, zero wait states, always okay
  assign addr_ok   = HSEL & HTRANS[1] & HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_q;

  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit(HADDR, OFS_RESET_CONTROL_REG)) begin
      read_mux[7:0] = reset_control_reg_q;
    end else if (hit(HADDR, OFS_RESET_CONTROL_REG_THREE)) begin
      read_mux[7:0] = reset_control_reg_three_q;
    end else if (hit(HADDR, OFS_DEEP_SLEEP_CONTROL_LOW)) begin
      read_mux[7:0] = dscon_q;                                                  // [RQ15]
    end else if (hit(HADDR, OFS_STATUS)) begin
      read_mux[4:0]             = state_q;
      read_mux[STATUS_BATT_BIT] = batt_mode_q;
    end
  end

  // address phase capture; read data fetched here, shown in data phase
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & HWRITE;
      if (addr_ok) begin
        wr_addr_q <= HADDR;
      end
      if (addr_ok && !HWRITE) begin
        rdata_q <= read_mux;
      end
    end
  end

  // sticky flags survive system reset; hardware events beat software writes
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      reset_control_reg_q <= RESET_CONTROL_REG_RST;
    end else begin
      if (wr_pend_q && hit(wr_addr_q, OFS_RESET_CONTROL_REG)) begin
        reset_control_reg_q <= HWDATA[7:0] & RESET_CONTROL_REG_WMASK;                                     // [RQ4] [RQ19]
      end
      if (TRIP.core_low) begin
        reset_control_reg_q[RESET_CONTROL_REG_CORE_BO_BIT] <= 1'b0;                                       // [RQ3]
      end
      if (RESET_INSTR) begin
        reset_control_reg_q[RESET_CONTROL_REG_RI_BIT] <= 1'b0;                                            // [RQ19]
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      reset_control_reg_three_q <= RESET_CONTROL_REG_THREE_RST;
    end else begin
      if (wr_pend_q && hit(wr_addr_q, OFS_RESET_CONTROL_REG_THREE)) begin
        reset_control_reg_three_q <= HWDATA[7:0] & RESET_CONTROL_REG_THREE_WMASK;
      end
      if (supply_trip) begin
        reset_control_reg_three_q[RESET_CONTROL_REG_THREE_SBO_BIT] <= 1'b1;                                         // [RQ9]
      end
    end
  end

  // deep-sleep trip only records; it never enters the sequencer
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      dscon_q <= DEEP_SLEEP_CONTROL_LOW_RST;
    end else begin
      if (wr_pend_q && hit(wr_addr_q, OFS_DEEP_SLEEP_CONTROL_LOW)) begin
        dscon_q <= HWDATA[7:0] & DSCON_WMASK;
      end
      if (ds_trip) begin
        dscon_q[DEEP_SLEEP_CONTROL_LOW_DSBO_BIT] <= 1'b1;                                       // [RQ14] [RQ15]
      end
    end
  end

  assign SYSTEM_RESET  = sys_rst_q;
  assign BATTERY_MODE  = batt_mode_q;
  assign CLOCK_REINIT  = clk_reinit_q;
  assign CONFIG_RELOAD = cfg_reload_q;

  // checking helpers: quiet run state, and cycles since last voltage trip
  logic          calm;
  logic          pwrt_owed_q;
  logic [CW-1:0] quiet_cnt_q;
  assign calm = (state_q == ST_RUN) & ~TRIP.core_low & ~batt_trip & ~supply_trip
              & MASTER_CLEAR_PIN_N & ~master_clear_pin_rst_q & ~RESET_INSTR & ~STACK_ERR;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pwrt_owed_q <= 1'b1;
      quiet_cnt_q <= '0;
    end else begin
      if (volt_src) begin
        pwrt_owed_q <= 1'b1;
      end else if (state_q == ST_RUN) begin
        pwrt_owed_q <= 1'b0;
      end
      if (volt_src) begin
        quiet_cnt_q <= '0;
      end else if (quiet_cnt_q != '1) begin
        quiet_cnt_q <= quiet_cnt_q + CW'(1);
      end
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  sequence instr_start_s;
    calm ##0 RESET_INSTR;
  endsequence

  sequence instr_quiet_s;
    instr_start_s ##1 (!volt_src)[*4];
  endsequence

  core_trip_reset_a: assert property (TRIP.core_low |=> SYSTEM_RESET && CLOCK_REINIT) // [RQ1]
    else $error("core trip did not force system reset");

  core_flag_clear_a: assert property (TRIP.core_low |=> !reset_control_reg_q[RESET_CONTROL_REG_CORE_BO_BIT]) // [RQ3]
    else $error("core brown-out flag not cleared");

  pwrt_release_a: assert property ($fell(SYSTEM_RESET) && $past(pwrt_owed_q)     // [RQ2] [RQ8] [RQ22]
                                   |-> $past(quiet_cnt_q) >= CW'(PWRT_CYCLES - 1))
    else $error("reset released before power-up timer expired");

  supply_gate_a: assert property (calm && !CFG.supply_brownout_enable          // [RQ5]
                                  && TRIP.supply_low_1v8 && TRIP.supply_low_2v0 |=> !SYSTEM_RESET)
    else $error("disabled supply detector caused reset");

  supply_level_a: assert property ((state_q == ST_RUN) && !DEEP_SLEEP          // [RQ6] [RQ7] [RQ9]
                                   && CFG.supply_brownout_enable && CFG.supply_brownout_level_select
                                   && TRIP.supply_low_2v0 |=> SYSTEM_RESET && reset_control_reg_three_q[RESET_CONTROL_REG_THREE_SBO_BIT])
    else $error("2.0V supply trip did not reset and flag");

  batt_off_a: assert property (calm && !CFG.battery_brownout_enable && TRIP.battery_low // [RQ11]
                               |=> !SYSTEM_RESET && (BATTERY_MODE == $past(BATTERY_MODE)))
    else $error("disabled battery detector had an effect");

  ds_nowake_a: assert property (calm && DEEP_SLEEP && TRIP.deep_sleep_low      // [RQ14] [RQ15]
                                && CFG.deep_sleep_brownout_enable |=> !SYSTEM_RESET && dscon_q[DEEP_SLEEP_CONTROL_LOW_DSBO_BIT])
    else $error("deep-sleep trip woke device or was not recorded");

  instr_hold_a: assert property (instr_start_s |=> (SYSTEM_RESET && !CLOCK_REINIT)[*4]) // [RQ16]
    else $error("instruction reset shorter than one instruction cycle");

  instr_release_a: assert property (instr_quiet_s |=> !SYSTEM_RESET && CONFIG_RELOAD) // [RQ17]
    else $error("instruction reset not released with config reload");

  ri_clear_a: assert property (RESET_INSTR |=> !reset_control_reg_q[RESET_CONTROL_REG_RI_BIT])            // [RQ19]
    else $error("reset command flag not cleared");

  master_clear_pin_filter_a: assert property ($rose(master_clear_pin_rst_q)                           // [RQ18] [RQ21]
                                  |-> $past(master_clear_pin_cnt_q) == FW'(MASTER_CLEAR_PIN_FILT_CYCLES - 1) && $past(!MASTER_CLEAR_PIN_N))
    else $error("master clear accepted before filter count");

  stack_gate_a: assert property ((state_q == ST_RUN) && !volt_src && !master_clear_pin_rst_q && !RESET_INSTR // [RQ20]
                                 && STACK_ERR && !CFG.stack_error_reset_enable |=> !SYSTEM_RESET)
    else $error("stack error reset while disabled");

  // an enabled stack error behaves like the reset instruction, clock kept
  stack_go_a: assert property ((state_q == ST_RUN) && !volt_src && !master_clear_pin_rst_q               // [RQ20]
                               && STACK_ERR && CFG.stack_error_reset_enable |=> SYSTEM_RESET && !CLOCK_REINIT)
    else $error("enabled stack error did not reset");

  // lower trip point on its own; any state is preempted by a voltage trip
  supply_low18_a: assert property (!DEEP_SLEEP && CFG.supply_brownout_enable          // [RQ6] [RQ7] [RQ9]
                                   && !CFG.supply_brownout_level_select && TRIP.supply_low_1v8
                                   |=> SYSTEM_RESET && reset_control_reg_three_q[RESET_CONTROL_REG_THREE_SBO_BIT])
    else $error("1.8V supply trip did not reset and flag");

  // battery mode latches on an enabled trip without main supply, and ends with its return
  batt_enter_a: assert property (CFG.battery_brownout_enable && TRIP.battery_low && !VDD_PRESENT // [RQ12]
                                 |=> SYSTEM_RESET && BATTERY_MODE)
    else $error("battery trip did not reset into battery mode");

  batt_stay_a: assert property (BATTERY_MODE && !VDD_PRESENT |=> BATTERY_MODE)      // [RQ12]
    else $error("battery mode left while supply absent");

  batt_exit_a: assert property (VDD_PRESENT |=> !BATTERY_MODE)                       // [RQ12]
    else $error("battery mode kept after supply returned");

  // reload is a single-cycle strobe
  reload_pulse_a: assert property (CONFIG_RELOAD |=> !CONFIG_RELOAD)                 // [RQ17]
    else $error("config reload wider than one cycle");

  master_clear_pin_accept_a: assert property ($rose(master_clear_pin_rst_q) && (state_q == ST_RUN) && !volt_src // [RQ18]
                                  |=> SYSTEM_RESET && CLOCK_REINIT)
    else $error("filtered master clear did not reset");

endmodule

/* File: rtl/rsc_pkg.sv */
// Summary of operation
// [RQ1] core brown-out detection is always on, fixed trip near 1.6V, forces reset
// [RQ2] after core recovery, reset releases only once the power-up timer expires
// [RQ3] core brown-out clears the core brown-out flag, reset control bit 0
// [RQ4] software sets the core brown-out flag after each brown-out or power-on
// [RQ5] supply brown-out detection works only when its enable config bit is set
// [RQ6] supply trip level is 1.8V or 2.0V, chosen by the level select bit
// [RQ7] supply brown-out acts in run, idle and normal sleep, holding reset
// [RQ8] after supply recovery, reset holds until the power-up timer period elapses
// [RQ9] supply brown-out reset sets the supply brown-out flag, bit 3 of register three
// [RQ10] new designs should watch the supply brown-out rather than the core one
// [RQ11] battery brown-out disabled by its config bit gives no reset and no sign
// [RQ12] enabled battery brown-out resets, then runs in battery mode until supply returns
// [RQ13] deep-sleep brown-out detection works only when its enable config bit is set
// [RQ14] deep-sleep brown-out never wakes the device from deep sleep
// [RQ15] deep-sleep brown-out is recorded in bit 1 of deep-sleep control low
// [RQ16] reset instruction asserts system reset but leaves the clock source running
// [RQ17] after reset instruction, config reloads and reset releases next instruction cycle
// [RQ18] master-clear input passes a noise filter so short pulses cause no reset
// [RQ19] reset instruction clears the reset command flag, bit 4; software sets it
// [RQ20] stack overflow or underflow resets only when stack error reset is enabled
// [RQ21] master-clear low pulses shorter than a set cycle count are rejected
// [RQ22] all sources drive one system reset, voltage sources held to timer expiry
package rsc_pkg;

  // clock and timing, figures in ns, counts derived
  localparam int MCLK_NS       = 50;
  localparam int PWRT_NS       = 1_000_000;
  localparam int PWRT_CYC      = (PWRT_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int MASTER_CLEAR_PIN_FILT_NS  = 200;
  localparam int MASTER_CLEAR_PIN_FILT_CYC = (MASTER_CLEAR_PIN_FILT_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int INSTR_CYC_NS  = 200;
  localparam int INSTR_CYC     = (INSTR_CYC_NS + MCLK_NS - 1) / MCLK_NS;

  // register byte offsets
  localparam logic [7:0] OFS_RESET_CONTROL_REG   = 8'h00;
  localparam logic [7:0] OFS_RESET_CONTROL_REG_THREE  = 8'h04;
  localparam logic [7:0] OFS_DEEP_SLEEP_CONTROL_LOW = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // field positions
  localparam int RESET_CONTROL_REG_CORE_BO_BIT  = 0;
  localparam int RESET_CONTROL_REG_POR_BIT      = 1;
  localparam int RESET_CONTROL_REG_RI_BIT       = 4;
  localparam int RESET_CONTROL_REG_THREE_SPOR_BIT    = 2;
  localparam int RESET_CONTROL_REG_THREE_SBO_BIT     = 3;
  localparam int DEEP_SLEEP_CONTROL_LOW_DSBO_BIT   = 1;
  localparam int STATUS_BATT_BIT   = 5;

  // reset values and software write masks
  localparam logic [7:0] RESET_CONTROL_REG_RST    = 8'h10;
  localparam logic [7:0] RESET_CONTROL_REG_THREE_RST   = 8'h00;
  localparam logic [7:0] DEEP_SLEEP_CONTROL_LOW_RST  = 8'h00;
  localparam logic [7:0] RESET_CONTROL_REG_WMASK  = 8'h13;
  localparam logic [7:0] RESET_CONTROL_REG_THREE_WMASK = 8'h0C;
  localparam logic [7:0] DSCON_WMASK = 8'h02;

  // sequencer states
  typedef enum logic [4:0] {
    ST_RUN   = 5'b0_0001,
    ST_VHOLD = 5'b0_0010,
    ST_PWRT  = 5'b0_0100,
    ST_MHOLD = 5'b0_1000,
    ST_IRST  = 5'b1_0000
  } rsc_state_e;

  // configuration word bits
  typedef struct packed {
    logic stack_error_reset_enable;
    logic supply_brownout_enable;
    logic supply_brownout_level_select;  // 1 = 2.0V, 0 = 1.8V
    logic battery_brownout_enable;
    logic deep_sleep_brownout_enable;
  } rsc_cfg_s;

  // analog detector trips, high while below threshold
  typedef struct packed {
    logic core_low;
    logic supply_low_1v8;
    logic supply_low_2v0;
    logic battery_low;
    logic deep_sleep_low;
  } rsc_trip_s;

endpackage

/* File: tb/rsc_detector_model.sv */
`timescale 1ns/100ps
module rsc_detector_model #(
  parameter int CORE_MV   = 1600,
  parameter int SUP_LO_MV = 1800,
  parameter int SUP_HI_MV = 2000,
  parameter int BAT_MV    = 1500,
  parameter int DS_MV     = 1500
) (
  input  var  int                 core_mv,
  input  var  int                 sup_mv,
  input  var  int                 bat_mv,
  input  var  int                 ds_mv,
  input  wire logic [4:0]         cfg_bits,
  output wire rsc_pkg::rsc_trip_s trip,
  output wire rsc_pkg::rsc_cfg_s  cfg
);
  import rsc_pkg::*;

  // comparators, high while the rail sits below its trip point
  assign trip.core_low       = core_mv < CORE_MV;
  assign trip.supply_low_1v8 = sup_mv < SUP_LO_MV;
  assign trip.supply_low_2v0 = sup_mv < SUP_HI_MV;
  assign trip.battery_low    = bat_mv < BAT_MV;
  assign trip.deep_sleep_low = ds_mv < DS_MV;

  // fuse bits; detectors report regardless, gating is left to the block
  assign cfg = rsc_cfg_s'(cfg_bits);
endmodule

/* File: tb/rsc_reset_source_controller_tb.sv */
`timescale 1ns/100ps
module rsc_reset_source_controller_tb;
  import rsc_pkg::*;
  localparam int          PWRT = 8;
  localparam int          FILT = 4;
  localparam logic [31:0] A_RC = 32'h0;
  localparam logic [31:0] A_R3 = 32'h4;
  localparam logic [31:0] A_DS = 32'h8;
  localparam logic [31:0] A_ST = 32'hC;

  typedef struct {
    logic [4:0]  cfg;
    int          core, sup, bat, ds;
    logic        dsl, rst;
    logic [31:0] addr, pre, mask, exp;
  } rsc_row_s;

  logic        mclk = 1'h0;
  logic        resetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, sys_rst, batt_mode, clk_reinit, cfg_reload, seen;
  logic        master_clear_pin_n = 1'h1, vdd_ok = 1'h1, deep_sleep = 1'h0, rst_instr = 1'h0, stack_err = 1'h0;
  logic [4:0]  cfg_bits = 5'h1B;
  int          core_mv = 1800, sup_mv = 3300, bat_mv = 3000, ds_mv = 3300;
  int          miscompares = 0, comparisons = 0, n;
  rsc_trip_s   trip;
  rsc_cfg_s    cfg;

  // ordinary trip cases: cfg, core, supply, battery, deep-sleep mV, sleep, reset, register view
  rsc_row_s rows [9] = '{
    '{5'h1B, 1500, 3300, 3000, 3300, 1'h0, 1'h1, A_RC, 32'h13, 32'h1, 32'h0}, // core
    '{5'h1B, 1800, 1900, 3000, 3300, 1'h0, 1'h0, A_R3, 32'h0, 32'h8, 32'h0},  // 1.8V level
    '{5'h1F, 1800, 1900, 3000, 3300, 1'h0, 1'h1, A_R3, 32'h0, 32'h8, 32'h8},  // 2.0V level
    '{5'h13, 1800, 1700, 3000, 3300, 1'h0, 1'h0, A_R3, 32'h0, 32'h8, 32'h0},  // supply off
    '{5'h1B, 1800, 3300, 1000, 3300, 1'h0, 1'h1, A_ST, 32'h0, 32'h20, 32'h0}, // battery on
    '{5'h19, 1800, 3300, 1000, 3300, 1'h0, 1'h0, A_ST, 32'h0, 32'h20, 32'h0}, // battery off
    '{5'h1B, 1800, 3300, 3000, 1000, 1'h1, 1'h0, A_DS, 32'h0, 32'h2, 32'h2},  // deep sleep on
    '{5'h1A, 1800, 3300, 3000, 1000, 1'h1, 1'h0, A_DS, 32'h0, 32'h2, 32'h0},  // deep sleep off
    '{5'h1B, 1800, 1700, 3000, 3300, 1'h0, 1'h1, A_R3, 32'h0, 32'h8, 32'h8}   // 1.8V trip
  };

  rsc_detector_model PARTNER (.core_mv(core_mv), .sup_mv(sup_mv), .bat_mv(bat_mv), .ds_mv(ds_mv),
                              .cfg_bits(cfg_bits), .trip(trip), .cfg(cfg));

  // hready loops back from the only slave
  rsc_reset_source_controller #(.PWRT_CYCLES(PWRT), .MASTER_CLEAR_PIN_FILT_CYCLES(FILT)) DUT (
    .MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .TRIP(trip), .CFG(cfg), .MASTER_CLEAR_PIN_N(master_clear_pin_n), .VDD_PRESENT(vdd_ok),
    .DEEP_SLEEP(deep_sleep), .RESET_INSTR(rst_instr), .STACK_ERR(stack_err), .SYSTEM_RESET(sys_rst),
    .BATTERY_MODE(batt_mode), .CLOCK_REINIT(clk_reinit), .CONFIG_RELOAD(cfg_reload));

  // 20 MHz system clock
  always #25 mclk = ~mclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one single-word transfer; holds each phase until hready is seen high
  // no wait limit here: a stalled bus is ended by the watchdog alone
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    check(hresp, 1'h0);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'h0, a, 32'h0);
    check(rd & m, e);
  endtask

  // outputs are looked at one step after the edge
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (5) tick();
    check({sys_rst, clk_reinit, cfg_reload, hreadyout}, 32'hD);
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    n = 0;
    do begin tick(); n++; end while (sys_rst === 1'h1 && n < 40);
    check(32'(n), 32'(PWRT));
    rd_chk(A_RC, 32'hFFFF_FFFF, 32'h10);
    rd_chk(A_R3, 32'hFFFF_FFFF, 32'h0);
    rd_chk(A_DS, 32'hFFFF_FFFF, 32'h0);
    rd_chk(A_ST, 32'hFFFF_FFFF, 32'h1);
    // write masks, read-only status and an unmapped word
    ahb(1'h1, A_RC, 32'hFF);
    rd_chk(A_RC, 32'hFFFF_FFFF, 32'h13);
    ahb(1'h1, A_R3, 32'hFF);
    rd_chk(A_R3, 32'hFFFF_FFFF, 32'hC);
    ahb(1'h1, A_ST, 32'hFF);
    rd_chk(A_ST, 32'hFFFF_FFFF, 32'h1);
    ahb(1'h1, 32'h40, 32'hFF);
    rd_chk(32'h40, 32'hFFFF_FFFF, 32'h0);
    $display("test reset and registers done");

    // the supply rows are the preferred detector in new systems
    foreach (rows[i]) begin
      ahb(1'h1, rows[i].addr, rows[i].pre);
      @(posedge mclk);
      cfg_bits <= rows[i].cfg;
      core_mv <= rows[i].core;
      sup_mv <= rows[i].sup;
      bat_mv <= rows[i].bat;
      ds_mv <= rows[i].ds;
      deep_sleep <= rows[i].dsl;
      repeat (4) tick();
      check(sys_rst, rows[i].rst);
      @(posedge mclk);
      core_mv <= 1800;
      sup_mv <= 3300;
      bat_mv <= 3000;
      ds_mv <= 3300;
      deep_sleep <= 1'h0;
      cfg_bits <= 5'h1B;
      n = 0;
      do begin tick(); n++; end while (sys_rst === 1'h1 && n < 40);
      if (rows[i].rst) check(32'(n), 32'(PWRT + 1));
      rd_chk(rows[i].addr, rows[i].mask, rows[i].exp);
    end
    $display("test detector rows done");

    // reset instruction keeps the clock and releases with a reload pulse
    ahb(1'h1, A_RC, 32'h13);
    @(posedge mclk);
    rst_instr <= 1'h1;
    @(posedge mclk);
    rst_instr <= 1'h0;
    #1;
    check({sys_rst, clk_reinit}, 32'h2);
    repeat (3) tick();
    check(sys_rst, 1'h1);
    tick();
    check({sys_rst, cfg_reload}, 32'h1);
    tick();
    check(cfg_reload, 1'h0);
    rd_chk(A_RC, 32'h10, 32'h0);
    $display("test reset instruction done");

    // stack error only resets when its fuse is set
    for (int e = 0; e < 2; e++) begin
      @(posedge mclk);
      cfg_bits <= {e[0], 4'hB};
      stack_err <= 1'h1;
      @(posedge mclk);
      stack_err <= 1'h0;
      #1;
      check(sys_rst, e[0]);
      repeat (8) tick();
    end
    $display("test stack error done");

    // a pulse one clock short of the filter must be ignored
    for (int w = FILT - 1; w <= FILT; w++) begin
      @(posedge mclk);
      master_clear_pin_n <= 1'h0;
      repeat (w) @(posedge mclk);
      master_clear_pin_n <= 1'h1;
      seen = 1'h0;
      repeat (6) begin tick(); seen |= sys_rst; end
      check(seen, w >= FILT);
      repeat (4) tick();
    end
    $display("test master clear filter done");

    // battery brown-out with the main supply gone, then supply returns
    @(posedge mclk);
    vdd_ok <= 1'h0;
    bat_mv <= 1000;
    repeat (3) tick();
    check({sys_rst, batt_mode}, 32'h3);
    @(posedge mclk);
    bat_mv <= 3000;
    repeat (PWRT + 3) tick();
    check({sys_rst, batt_mode}, 32'h1);
    rd_chk(A_ST, 32'h20, 32'h20);
    @(posedge mclk);
    vdd_ok <= 1'h1;
    repeat (2) tick();
    check(batt_mode, 1'h0);
    $display("test battery mode done");
    complete_run();
  end
endmodule
